/* design/rbd_defs.svh */
`ifndef RBD_DEFS_SVH
`define RBD_DEFS_SVH

// Reset stretch after supply good: 2^16 instruction cycles
`define RBD_STRETCH_CYCLES 17'h10000
`define RBD_STRETCH_W 17

// Start address after reset
`define RBD_BOOT_ADDR 14'h0800

// Program space
`define RBD_PRAM_BASE 14'h0000
`define RBD_PRAM_LAST 14'h01FF
`define RBD_VEC_LAST 14'h002F
`define RBD_PROM_BASE 14'h0800
`define RBD_PROM_LAST 14'h17FF

// Data space
`define RBD_PERIPH_BASE 14'h2000
`define RBD_PERIPH_LAST 14'h20FF
`define RBD_DRAM_BASE 14'h3800
`define RBD_DRAM_LAST 14'h39FF

// Reset values of core state
`define RBD_STACK_EMPTY 1'b1
`define RBD_IRQ_MASK_ALL 16'h0000
`define RBD_MODE_STATUS_REGISTER_RESET 7'h00

`endif

/* design/rbd_pkg.sv */
package rbd_pkg;

   typedef enum logic [1:0] {
      RBD_OFF = 2'b00,
      RBD_STRETCH = 2'b01,
      RBD_RUN = 2'b10
   } rbd_state_t;

   typedef enum logic [2:0] {
      RBD_SEL_NONE = 3'b000,
      RBD_SEL_PRAM = 3'b001,
      RBD_SEL_PROM = 3'b010,
      RBD_SEL_DRAM = 3'b011,
      RBD_SEL_PERIPH = 3'b100
   } rbd_sel_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [13:0] addr;
   } rbd_access_t;

   typedef struct packed {
      rbd_sel_t sel;
      logic [13:0] offset;
      logic writeEn;
      logic readEn;
      logic isVector;
   } rbd_route_t;

   typedef struct packed {
      logic stackEmpty;
      logic [15:0] irqMask;
      logic [6:0] modeStatusReset;
   } rbd_core_init_t;

endpackage

/* design/rbd_reset_decode.sv */
`timescale 1ns/1ps
`include "rbd_defs.svh"

// How it works
// (R1) Supply below threshold holds core and peripherals in reset; instruction clock output and routing keep running
// (R2) After supply good, stretch reset 2^16 cycles
// (R3) Falling supply below hysteresis level resets
// (R4) Low reset pin after power-up resets core and peripherals; instruction clock output and routing are not reset
// (R5) Reset empties stacks, masks interrupts, clears status
// (R6) Reset also reinitialises every motor peripheral
// (R7) After reset, fetch starts at ROM base
// (R8) Instruction clock output toggles each cycle, half the input clock rate
// (R9) Program addresses 0 to 511 select RAM
// (R10) Program ROM base through 4K block selects ROM
// (R11) Data RAM base 512 words selects data RAM
// (R12) Peripheral region routes to peripheral registers
// (R13) Reserved ranges select nothing, writes ignored
// (R14) Reset combined, synchronised, released on clock edge
module rbd_reset_decode (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic supplyAboveRelease,
   input wire logic supplyAboveHold,
   input wire logic extResetN,
   input wire rbd_pkg::rbd_access_t progAccess,
   input wire rbd_pkg::rbd_access_t dataAccess,
   output logic coreReset,
   output logic periphReset,
   output rbd_pkg::rbd_core_init_t coreInit,
   output logic bootLoad,
   output logic [13:0] bootAddr,
   output logic instrClockOut,
   output rbd_pkg::rbd_route_t progRoute,
   output rbd_pkg::rbd_route_t dataRoute
);
   import rbd_pkg::*;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic rbd_route_t decodeProg(input rbd_access_t acc);
      rbd_route_t r;
      r = '0;
      r.sel = RBD_SEL_NONE;
      if (acc.addr <= `RBD_PRAM_LAST) begin
         r.sel = RBD_SEL_PRAM; // (R9)
         r.offset = acc.addr - `RBD_PRAM_BASE;
         r.isVector = (acc.addr <= `RBD_VEC_LAST);
      end else if (acc.addr >= `RBD_PROM_BASE && acc.addr <= `RBD_PROM_LAST) begin
         r.sel = RBD_SEL_PROM; // (R10)
         r.offset = acc.addr - `RBD_PROM_BASE;
      end
      // ROM is never written; reserved selects nothing
      r.readEn = acc.valid && !acc.write && (r.sel != RBD_SEL_NONE); // (R13)
      r.writeEn = acc.valid && acc.write && (r.sel == RBD_SEL_PRAM); // (R13)
      return r;
   endfunction

   function automatic rbd_route_t decodeData(input rbd_access_t acc);
      rbd_route_t r;
      r = '0;
      r.sel = RBD_SEL_NONE;
      if (acc.addr >= `RBD_DRAM_BASE && acc.addr <= `RBD_DRAM_LAST) begin
         r.sel = RBD_SEL_DRAM; // (R11)
         r.offset = acc.addr - `RBD_DRAM_BASE;
      end else if (acc.addr >= `RBD_PERIPH_BASE && acc.addr <= `RBD_PERIPH_LAST) begin
         r.sel = RBD_SEL_PERIPH; // (R12)
         r.offset = acc.addr - `RBD_PERIPH_BASE;
      end
      r.readEn = acc.valid && !acc.write && (r.sel != RBD_SEL_NONE); // (R13)
      r.writeEn = acc.valid && acc.write && (r.sel != RBD_SEL_NONE); // (R13)
      return r;
   endfunction

   // ****************************************
   // Supply monitor with hysteresis
   // ****************************************
   logic supplyGood_reg;
   logic resetReq;

   // Good once above release level, lost only below hold level
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         supplyGood_reg <= 1'b0;
      end else if (!supplyAboveHold) begin
         supplyGood_reg <= 1'b0; // (R3)
      end else if (supplyAboveRelease) begin
         supplyGood_reg <= 1'b1;
      end
   end

   // Combined asynchronous request, same-cycle assertion
   assign resetReq = sys_rst || !supplyAboveHold || !extResetN; // (R14)

   // ****************************************
   // Reset synchroniser
   // ****************************************
   logic syncA_reg;
   logic syncB_reg;

   always_ff @(posedge clk or posedge resetReq) begin
      if (resetReq) begin
         syncA_reg <= 1'b0; // (R14)
         syncB_reg <= 1'b0;
      end else begin
         syncA_reg <= 1'b1;
         syncB_reg <= syncA_reg;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   rbd_state_t state_reg;
   rbd_state_t state_next;
   logic [`RBD_STRETCH_W-1:0] count_reg;
   logic stretchDone;

   assign stretchDone = (count_reg == `RBD_STRETCH_CYCLES - 17'h00001);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RBD_OFF: begin
            if (supplyGood_reg && syncB_reg) begin
               state_next = RBD_STRETCH;
            end
         end
         RBD_STRETCH: begin
            if (stretchDone) begin
               state_next = RBD_RUN; // (R2)
            end
         end
         RBD_RUN: begin
            state_next = RBD_RUN;
         end
         default: begin
            state_next = RBD_OFF;
         end
      endcase
      if (!supplyGood_reg || !syncB_reg) begin
         state_next = RBD_OFF; // (R1)
      end
   end

   always_ff @(posedge clk or posedge resetReq) begin
      if (resetReq) begin
         state_reg <= RBD_OFF; // (R1) (R4)
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or posedge resetReq) begin
      if (resetReq) begin
         count_reg <= '0;
      end else if (state_reg == RBD_STRETCH) begin
         count_reg <= count_reg + 17'h00001; // (R2)
      end else begin
         count_reg <= '0;
      end
   end

   // ****************************************
   // Reset outputs and core init values
   // ****************************************
   always_ff @(posedge clk or posedge resetReq) begin
      if (resetReq) begin
         coreReset <= 1'b1; // (R4) (R14)
         periphReset <= 1'b1; // (R6)
      end else begin
         coreReset <= (state_next != RBD_RUN); // (R1) (R2)
         periphReset <= (state_next != RBD_RUN); // (R6)
      end
   end

   always_ff @(posedge clk or posedge resetReq) begin
      if (resetReq) begin
         coreInit.stackEmpty <= `RBD_STACK_EMPTY; // (R5)
         coreInit.irqMask <= `RBD_IRQ_MASK_ALL; // (R5)
         coreInit.modeStatusReset <= `RBD_MODE_STATUS_REGISTER_RESET; // (R5)
      end else begin
         coreInit.stackEmpty <= `RBD_STACK_EMPTY;
         coreInit.irqMask <= `RBD_IRQ_MASK_ALL;
         coreInit.modeStatusReset <= `RBD_MODE_STATUS_REGISTER_RESET;
      end
   end

   // One-cycle load of the fetch address as reset ends
   always_ff @(posedge clk or posedge resetReq) begin
      if (resetReq) begin
         bootLoad <= 1'b0;
         bootAddr <= `RBD_BOOT_ADDR;
      end else begin
         bootLoad <= (state_reg != RBD_RUN) && (state_next == RBD_RUN); // (R7)
         bootAddr <= `RBD_BOOT_ADDR; // (R7)
      end
   end

   // ****************************************
   // Instruction clock output
   // ****************************************
   // clk is already the instruction-rate clock; toggle marks each cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         instrClockOut <= 1'b0;
      end else begin
         instrClockOut <= ~instrClockOut; // (R8)
      end
   end

   // ****************************************
   // Registered routing
   // ****************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         progRoute <= '0;
         dataRoute <= '0;
      end else begin
         progRoute <= decodeProg(progAccess);
         dataRoute <= decodeData(dataAccess);
      end
   end

endmodule

/* test/rbd_supply_model.sv */
`timescale 1ns/1ps
// ***
// Supply comparators and reset pin
// ***
module rbd_supply_model #(
   parameter logic [7:0] THRESH = 8'h64,
   parameter logic [7:0] HYST = 8'h0A
) (
   input wire logic [7:0] level,
   input wire logic resetReq,
   output logic supplyAboveRelease,
   output logic supplyAboveHold,
   output logic extResetN
);
   assign supplyAboveRelease = level >= THRESH;
   assign supplyAboveHold = level > THRESH - HYST;
   assign extResetN = !resetReq;
endmodule

/* test/rbd_reset_decode_asserts.sv */
`timescale 1ns/1ps
module rbd_reset_decode_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic supplyAboveHold,
   input wire logic extResetN,
   input wire rbd_pkg::rbd_access_t progAccess,
   input wire rbd_pkg::rbd_access_t dataAccess,
   input wire logic coreReset,
   input wire logic periphReset,
   input wire rbd_pkg::rbd_core_init_t coreInit,
   input wire logic bootLoad,
   input wire logic [13:0] bootAddr,
   input wire logic instrClockOut,
   input wire rbd_pkg::rbd_route_t progRoute,
   input wire rbd_pkg::rbd_route_t dataRoute
);
   import rbd_pkg::*;
   // ***
   // Checks
   // ***
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [16:0] hiCnt;
   // Reset-high cycles since the last reset source let go
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hiCnt <= 17'h00000;
      end else if (!coreReset || !extResetN || !supplyAboveHold) begin
         hiCnt <= 17'h00000;
      end else if (!hiCnt[16]) begin
         hiCnt <= hiCnt + 17'h00001;
      end
   end
   sup_low_a: assert property (!supplyAboveHold |-> coreReset)
      else $error("core out of reset with supply low");
   pin_rst_a: assert property (!extResetN |-> coreReset)
      else $error("reset pin ignored");
   periph_rst_a: assert property (periphReset == coreReset)
      else $error("peripheral reset differs from core reset");
   init_val_a: assert property (coreReset |-> coreInit == {1'b1, 16'h0000, 7'h00})
      else $error("core init values wrong");
   stretch_len_a: assert property ($fell(coreReset) |-> hiCnt[16])
      else $error("reset released too early");
   boot_fetch_a: assert property ($fell(coreReset) |-> bootLoad && bootAddr == 14'h0800)
      else $error("boot fetch missing");
   boot_once_a: assert property (bootLoad |=> !bootLoad)
      else $error("boot pulse too long");
   clk_div_a: assert property (1 |=> instrClockOut != $past(instrClockOut))
      else $error("clock output not toggling");
   rom_sel_a: assert property (progAccess.valid && progAccess.addr inside {[14'h0800:14'h17FF]}
      |=> progRoute.sel == RBD_SEL_PROM && !progRoute.writeEn) else $error("rom decode wrong");
   per_sel_a: assert property (dataAccess.valid && dataAccess.addr[13:8] == 6'h20
      |=> dataRoute.sel == RBD_SEL_PERIPH) else $error("peripheral decode wrong");
   rsv_sel_a: assert property (dataAccess.valid && dataAccess.addr inside {[14'h2100:14'h37FF]}
      |=> dataRoute.sel == RBD_SEL_NONE && !dataRoute.writeEn) else $error("reserved decoded");
   pram_sel_a: assert property (progAccess.valid && progAccess.addr inside {[14'h0000:14'h01FF]}
      |=> progRoute.sel == RBD_SEL_PRAM) else $error("program ram decode wrong");
   dram_sel_a: assert property (dataAccess.valid && dataAccess.addr inside {[14'h3800:14'h39FF]}
      |=> dataRoute.sel == RBD_SEL_DRAM) else $error("data ram decode wrong");
endmodule
bind rbd_reset_decode rbd_reset_decode_chk rbd_reset_decode_chk_i (.*);

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import rbd_pkg::*;
   logic clk, sys_rst, resetReq, supA, supH, extN, ick, ickPrev;
   logic [7:0] level;
   rbd_access_t pa, da;
   logic coreReset, periphReset, bootLoad;
   rbd_core_init_t ci;
   logic [13:0] bootAddr;
   rbd_route_t pr, dr;
   int miscompares = 0, n_compared = 0, n;
   logic [13:0] corners [18] = '{14'h0000, 14'h002F, 14'h0030, 14'h01FF, 14'h0200, 14'h07FF,
      14'h0800, 14'h17FF, 14'h1800, 14'h1FFF, 14'h2000, 14'h20FF, 14'h2100, 14'h37FF,
      14'h3800, 14'h39FF, 14'h3A00, 14'h3FFF};
   rbd_supply_model rbd_supply_model_i (.level(level), .resetReq(resetReq),
      .supplyAboveRelease(supA), .supplyAboveHold(supH), .extResetN(extN));
   rbd_reset_decode rbd_reset_decode_i (.clk(clk), .sys_rst(sys_rst), .supplyAboveRelease(supA),
      .supplyAboveHold(supH), .extResetN(extN), .progAccess(pa), .dataAccess(da),
      .coreReset(coreReset), .periphReset(periphReset), .coreInit(ci), .bootLoad(bootLoad),
      .bootAddr(bootAddr), .instrClockOut(ick), .progRoute(pr), .dataRoute(dr));
   // ***
   // Helpers
   // ***
   function automatic logic [13:0] expOff(logic [13:0] a, logic prog);
      if (prog && a <= 14'h01FF) return a;
      if (prog && a >= 14'h0800 && a <= 14'h17FF) return a - 14'h0800;
      if (!prog && a >= 14'h2000 && a <= 14'h20FF) return a - 14'h2000;
      if (!prog && a >= 14'h3800 && a <= 14'h39FF) return a - 14'h3800;
      return 14'h0000;
   endfunction
   function automatic logic [5:0] expRoute(logic [13:0] a, logic w, logic v, logic prog);
      rbd_sel_t s;
      s = RBD_SEL_NONE;
      if (prog && a <= 14'h01FF) s = RBD_SEL_PRAM;
      if (prog && a >= 14'h0800 && a <= 14'h17FF) s = RBD_SEL_PROM;
      if (!prog && a[13:8] == 6'h20) s = RBD_SEL_PERIPH;
      if (!prog && a >= 14'h3800 && a <= 14'h39FF) s = RBD_SEL_DRAM;
      return {s, v && w && s != RBD_SEL_NONE && s != RBD_SEL_PROM, v && !w && s != RBD_SEL_NONE,
         prog && a <= 14'h002F};
   endfunction
   task check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wrap_up;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task acc(logic [13:0] pAddr, logic [13:0] dAddr, logic w, logic v);
      @(posedge clk);
      pa <= {v, w, pAddr};
      da <= {v, w, dAddr};
      @(posedge clk);
      #1;
      check("progRoute", {pr.sel, pr.writeEn, pr.readEn, pr.isVector},
         expRoute(pAddr, w, v, 1'b1));
      check("dataRoute", {dr.sel, dr.writeEn, dr.readEn, dr.isVector},
         expRoute(dAddr, w, v, 1'b0));
      check("progOffset", pr.offset, expOff(pAddr, 1'b1));
      check("dataOffset", dr.offset, expOff(dAddr, 1'b0));
   endtask
   // ***
   // Stimulus
   // ***
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   initial begin
      #(4 * 80000);
      miscompares++;
      wrap_up;
   end
   initial begin
      void'($urandom(32'h0CC4));
      sys_rst = 1;
      level = 8'h00;
      resetReq = 0;
      pa = '0;
      da = '0;
      repeat (6) @(posedge clk);
      sys_rst <= 0;
      level <= 8'h5F;
      repeat (10) @(posedge clk);
      #1 check("coreReset", coreReset, 1);
      foreach (corners[i]) acc(corners[i], corners[i], i[0], 1'b1);
      acc(14'h0100, 14'h3800, 1'b1, 1'b0);
      repeat (60) acc(14'($urandom), 14'($urandom), 1'($urandom), 1'($urandom));
      @(posedge clk) level <= 8'hC8;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (coreReset !== 1'b0 && n < 70000);
      check("stretch", n >= 65536 && n <= 65545, 1);
      check("boot", {bootLoad, bootAddr}, {1'b1, 14'h0800});
      ickPrev = ick;
      @(posedge clk) level <= 8'h5F;
      #1 check("instruction_clock_output", ick, !ickPrev);
      repeat (5) @(posedge clk);
      #1 check("holdRun", coreReset, 0);
      @(posedge clk) resetReq <= 1;
      @(posedge clk);
      #1 check("pinReset", {coreReset, periphReset, ci}, {2'b11, 1'b1, 16'h0000, 7'h00});
      @(posedge clk) resetReq <= 0;
      repeat (100) @(posedge clk);
      #1 check("pinStretch", {coreReset, bootLoad}, 2'b10);
      @(posedge clk) level <= 8'h32;
      repeat (3) @(posedge clk);
      #1 check("supplyLow", coreReset, 1);
      wrap_up;
   end
endmodule
